// [logic/bah_params.svh]
`ifndef BAH_PARAMS_SVH
`define BAH_PARAMS_SVH
// register byte offsets
`define BAH_OFF_CTRL  12'h000
`define BAH_OFF_PSTAT 12'h004
`define BAH_OFF_SSTAT 12'h008
`define BAH_OFF_USTAT 12'h00C
`define BAH_OFF_UMASK 12'h010
`define BAH_OFF_USEV  12'h014
`define BAH_OFF_PTR   12'h018
`define BAH_OFF_HLOG  12'h01C
// control bits
`define BAH_CTL_SEE  0
`define BAH_CTL_FEN  1
`define BAH_CTL_NFEN 2
`define BAH_CTL_SPR  3
`define BAH_CTL_MAM  4
// primary status bits
`define BAH_PST_SSERR 0
`define BAH_PST_PMDP  1
`define BAH_PST_FDET  2
`define BAH_PST_NFDET 3
// secondary status bits
`define BAH_SST_RTA  0
`define BAH_SST_DPE  1
`define BAH_SST_SMDP 2
`define BAH_SST_STA  3
`define BAH_SST_RMA  4
// secondary uncorrectable error indices
`define BAH_ERR_RTA 0
`define BAH_ERR_UDE 1
`define BAH_NERR    2
// first error pointer valid bit
`define BAH_PTR_VLD 4
// reset values
`define BAH_CTRL_RST 5'h00
`define BAH_MASK_RST 2'h0
`define BAH_SEV_RST  2'h0
// all-ones read data
`define BAH_ALL_ONES 32'hFFFF_FFFF
`endif

// [logic/bah_pkg.sv]
`include "bah_params.svh"
package bah_pkg;
  // top-level state
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [3:0]  pstat;
    logic [4:0]  sstat;
    logic [1:0]  ustat;
    logic [1:0]  umask;
    logic [1:0]  usev;
    logic        ptr_valid;
    logic        ptr_idx;
    logic [31:0] hdr_log;
    logic [31:0] prdata;
    logic        pslverr;
    logic        dn_discard;
    logic        cpl_ca;
    logic        fwd;
    logic        poison;
    logic        up_discard;
    logic        perr_drive;
    logic        msg_valid;
    logic        msg_fatal;
  } bah_top_st_t;
  // upstream completion responder state
  typedef struct packed {
    logic        ta;
    logic        normal;
    logic [31:0] data;
    logic        set_sta;
    logic        set_rma;
    logic        set_rta;
  } bah_resp_st_t;
endpackage

// [logic/bah_core_if.sv]
`timescale 1ns/1ps
interface bah_core_if;
  // error reporting group
  logic [1:0]  ev;
  logic [1:0]  mask;
  logic [1:0]  sev;
  logic        see;
  logic        fen;
  logic        nfen;
  logic        ptr_valid;
  logic [1:0]  log_sel;
  logic        msg_valid;
  logic        msg_fatal;
  logic        set_fatal;
  logic        set_nonfatal;
  logic        set_sserr;
  // upstream completion group
  logic        cpl;
  logic        ur;
  logic        ca;
  logic        io_wr;
  logic        mam;
  logic        ta;
  logic        normal;
  logic [31:0] data;
  logic        set_sta;
  logic        set_rma;
  logic        set_rta;
  modport top (output ev, mask, sev, see, fen, nfen, ptr_valid, cpl, ur, ca, io_wr, mam,
               input log_sel, msg_valid, msg_fatal, set_fatal, set_nonfatal, set_sserr,
               input ta, normal, data, set_sta, set_rma, set_rta);
  modport rpt (input ev, mask, sev, see, fen, nfen, ptr_valid,
               output log_sel, msg_valid, msg_fatal, set_fatal, set_nonfatal, set_sserr);
  modport rsp (input cpl, ur, ca, io_wr, mam,
               output ta, normal, data, set_sta, set_rma, set_rta);
endinterface

// [logic/bah_report.sv]
`timescale 1ns/1ps
module bah_report (
  // core link
  bah_core_if.rpt bus
);
  import bah_pkg::*;
  logic msg_f;
  logic msg_nf;
  logic found;

  // ************************************
  // severity, message and log selection
  // ************************************
  // lowest index wins the log when two errors land together
  always_comb begin
    msg_f = 1'b0;
    msg_nf = 1'b0;
    found = 1'b0;
    bus.log_sel = 2'b00;
    bus.set_fatal = 1'b0;
    bus.set_nonfatal = 1'b0;
    for (int i = 0; i < `BAH_NERR; i++) begin
      if (bus.ev[i]) begin
        if (bus.sev[i]) begin
          bus.set_fatal = 1'b1;
        end else begin
          bus.set_nonfatal = 1'b1;
        end
        if (!bus.mask[i] && (bus.see || (bus.sev[i] ? bus.fen : bus.nfen))) begin
          if (bus.sev[i]) begin
            msg_f = 1'b1;
          end else begin
            msg_nf = 1'b1;
          end
        end
        if (!bus.mask[i] && !bus.ptr_valid && !found) begin
          bus.log_sel[i] = 1'b1;
          found = 1'b1;
        end
      end
    end
    // a fatal message outranks a non-fatal one in the same cycle
    bus.msg_valid = msg_f | msg_nf;
    bus.msg_fatal = msg_f;
    bus.set_sserr = (msg_f | msg_nf) & bus.see;
  end
endmodule

// [logic/bah_resp.sv]
`timescale 1ns/1ps
module bah_resp (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // core link
  bah_core_if.rsp   bus
);
  import bah_pkg::*;
  bah_resp_st_t st;
  bah_resp_st_t next_st;

  // ************************************
  // answer to the waiting pci master
  // ************************************
  always_comb begin
    next_st = '0;
    if (bus.cpl && bus.ca) begin
      next_st.ta = 1'b1;
      next_st.set_rta = 1'b1;
    end else if (bus.cpl && bus.ur) begin
      next_st.set_rma = 1'b1;
      if (bus.mam) begin
        next_st.ta = 1'b1;
      end else begin
        // cleared mode is the compatible one: no error seen by the master
        next_st.normal = 1'b1;
        next_st.data = bus.io_wr ? 32'h0000_0000 : `BAH_ALL_ONES;
      end
    end
    next_st.set_sta = next_st.ta;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.ta = st.ta;
  assign bus.normal = st.normal;
  assign bus.data = st.data;
  assign bus.set_sta = st.set_sta;
  assign bus.set_rma = st.set_rma;
  assign bus.set_rta = st.set_rta;

  chk_ca_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.cpl && bus.ca |=> bus.ta && !bus.normal)
    else $error("completer abort did not target-abort");
  chk_ur_ones: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.cpl && bus.ur && !bus.ca && !bus.mam && !bus.io_wr |=> bus.normal && bus.data == `BAH_ALL_ONES)
    else $error("unsupported read in compatible mode not all ones");
endmodule

// [logic/bah_top.sv]
// Function
// - posted write target-aborted downstream: drop the rest of its data.
// - every downstream target-abort sets received-abort in secondary and uncorrectable status.
// - non-posted request target-aborted: return completer-abort completion upstream.
// - log header and first-error pointer if unmasked and pointer not valid.
// - send fatal/non-fatal message per severity when unmasked and enabled.
// - message sent with system-error enable sets signaled-system-error flag.
// - every such error sets fatal or non-fatal detected flag by severity.
// - upstream write with bad parity goes to PCIe as poisoned request, unless non-posted with parity response on.
// - unsupported read completion: target-abort if mode 1, else all-ones data.
// - unsupported I/O write completion: target-abort if mode 1, else normal.
// - completer-abort completion always target-aborts the PCI master.
// - upstream write data error sets detected-parity-error in secondary status.
// - non-posted data error, parity response on: discard, no forward, drive PERR#.
// - non-posted data error, parity response off: forward poisoned, no PERR#.
// - posted data error: PERR# and master-parity flag only with parity response.
// - every upstream write data error sets the uncorrectable-write-data flag.
// - master-abort mode is a control bit; cleared means compatible behaviour.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module bah_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // downstream target-abort events
  input  wire logic        dn_ta,
  input  wire logic        dn_posted,
  input  wire logic [31:0] dn_hdr,
  output logic             dn_discard,
  output logic             cpl_ca_valid,
  // upstream write data errors
  input  wire logic        up_wr_perr,
  input  wire logic        up_posted,
  input  wire logic [31:0] up_hdr,
  output logic             up_fwd,
  output logic             up_poison,
  output logic             up_discard,
  output logic             perr_out_n,
  output logic             perr_oe,
  // upstream completion status
  input  wire logic        up_cpl,
  input  wire logic        up_cpl_ur,
  input  wire logic        up_cpl_ca,
  input  wire logic        up_cpl_io_wr,
  output logic             pci_target_abort,
  output logic             pci_normal,
  output logic      [31:0] pci_rdata,
  // error message to pcie
  output logic             err_msg_valid,
  output logic             err_msg_fatal
);
  import bah_pkg::*;

  bah_top_st_t st;
  bah_top_st_t next_st;
  logic        wr_en;
  logic        setup;
  logic [11:0] word_addr;
  logic [31:0] wmask;
  logic [3:0]  p_set;
  logic [4:0]  s_set;
  logic [1:0]  u_set;
  logic        spr;

  bah_core_if core ();

  // ************************************
  // submodules
  // ************************************
  bah_report u_report (
    .bus (core)
  );

  bah_resp u_resp (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bus     (core)
  );

  // ************************************
  // apb decode
  // ************************************
  // zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign word_addr = {paddr[11:2], 2'b00};
  assign spr = st.ctrl[`BAH_CTL_SPR];

  // write-one-to-clear mask for the status registers
  assign wmask = wr_en ? pwdata : 32'h0000_0000;

  // ************************************
  // feeds to the report and responder
  // ************************************
  assign core.ev[`BAH_ERR_RTA] = dn_ta;
  assign core.ev[`BAH_ERR_UDE] = up_wr_perr;
  assign core.mask = st.umask;
  assign core.sev = st.usev;
  assign core.see = st.ctrl[`BAH_CTL_SEE];
  assign core.fen = st.ctrl[`BAH_CTL_FEN];
  assign core.nfen = st.ctrl[`BAH_CTL_NFEN];
  assign core.ptr_valid = st.ptr_valid;
  assign core.cpl = up_cpl;
  assign core.ur = up_cpl_ur;
  assign core.ca = up_cpl_ca;
  assign core.io_wr = up_cpl_io_wr;
  assign core.mam = st.ctrl[`BAH_CTL_MAM];

  // ************************************
  // status set terms
  // ************************************
  always_comb begin
    p_set = 4'h0;
    s_set = 5'h00;
    u_set = 2'h0;
    p_set[`BAH_PST_SSERR] = core.set_sserr;
    p_set[`BAH_PST_FDET] = core.set_fatal;
    p_set[`BAH_PST_NFDET] = core.set_nonfatal;
    s_set[`BAH_SST_RTA] = dn_ta | core.set_rta;
    s_set[`BAH_SST_DPE] = up_wr_perr;
    s_set[`BAH_SST_SMDP] = up_wr_perr & up_posted & spr;
    s_set[`BAH_SST_STA] = core.set_sta;
    s_set[`BAH_SST_RMA] = core.set_rma;
    u_set[`BAH_ERR_RTA] = dn_ta;
    u_set[`BAH_ERR_UDE] = up_wr_perr;
  end

  // ************************************
  // next state
  // ************************************
  // a set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    next_st = st;
    next_st.dn_discard = dn_ta & dn_posted;
    next_st.cpl_ca = dn_ta & ~dn_posted;
    next_st.fwd = 1'b0;
    next_st.poison = 1'b0;
    next_st.up_discard = 1'b0;
    next_st.perr_drive = 1'b0;
    if (up_wr_perr) begin
      if (up_posted) begin
        next_st.fwd = 1'b1;
        next_st.poison = 1'b1;
        next_st.perr_drive = spr;
      end else if (spr) begin
        next_st.up_discard = 1'b1;
        next_st.perr_drive = 1'b1;
      end else begin
        next_st.fwd = 1'b1;
        next_st.poison = 1'b1;
      end
    end
    next_st.msg_valid = core.msg_valid;
    next_st.msg_fatal = core.msg_fatal;
    // software writes
    if (wr_en && word_addr == `BAH_OFF_CTRL) begin
      next_st.ctrl = pwdata[4:0];
    end
    if (wr_en && word_addr == `BAH_OFF_UMASK) begin
      next_st.umask = pwdata[1:0];
    end
    if (wr_en && word_addr == `BAH_OFF_USEV) begin
      next_st.usev = pwdata[1:0];
    end
    next_st.pstat = st.pstat & ~((word_addr == `BAH_OFF_PSTAT) ? wmask[3:0] : 4'h0) | p_set;
    next_st.sstat = st.sstat & ~((word_addr == `BAH_OFF_SSTAT) ? wmask[4:0] : 5'h00) | s_set;
    next_st.ustat = st.ustat & ~((word_addr == `BAH_OFF_USTAT) ? wmask[1:0] : 2'h0) | u_set;
    // pointer drops once software clears the flag it points at
    next_st.ptr_valid = st.ptr_valid & next_st.ustat[st.ptr_idx];
    if (core.log_sel[`BAH_ERR_RTA]) begin
      next_st.hdr_log = dn_hdr;
      next_st.ptr_idx = 1'b0;
      next_st.ptr_valid = 1'b1;
    end else if (core.log_sel[`BAH_ERR_UDE]) begin
      next_st.hdr_log = up_hdr;
      next_st.ptr_idx = 1'b1;
      next_st.ptr_valid = 1'b1;
    end
    // read data and error answer are latched in the setup cycle
    if (setup) begin
      next_st.pslverr = 1'b0;
      case (word_addr)
        `BAH_OFF_CTRL: begin
          next_st.prdata = {27'h000_0000, st.ctrl};
        end
        `BAH_OFF_PSTAT: begin
          next_st.prdata = {28'h000_0000, st.pstat};
        end
        `BAH_OFF_SSTAT: begin
          next_st.prdata = {27'h000_0000, st.sstat};
        end
        `BAH_OFF_USTAT: begin
          next_st.prdata = {30'h0000_0000, st.ustat};
        end
        `BAH_OFF_UMASK: begin
          next_st.prdata = {30'h0000_0000, st.umask};
        end
        `BAH_OFF_USEV: begin
          next_st.prdata = {30'h0000_0000, st.usev};
        end
        `BAH_OFF_PTR: begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[`BAH_PTR_VLD] = st.ptr_valid;
          next_st.prdata[0] = st.ptr_idx;
        end
        `BAH_OFF_HLOG: begin
          next_st.prdata = st.hdr_log;
        end
        default: begin
          next_st.prdata = 32'h0000_0000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ************************************
  // state register
  // ************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.ctrl <= `BAH_CTRL_RST;
      st.umask <= `BAH_MASK_RST;
      st.usev <= `BAH_SEV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign dn_discard = st.dn_discard;
  assign cpl_ca_valid = st.cpl_ca;
  assign up_fwd = st.fwd;
  assign up_poison = st.poison;
  assign up_discard = st.up_discard;
  // PERR# only ever drives low; the pull-up restores it
  assign perr_out_n = ~st.perr_drive;
  assign perr_oe = st.perr_drive;
  assign pci_target_abort = core.ta;
  assign pci_normal = core.normal;
  assign pci_rdata = core.data;
  assign err_msg_valid = st.msg_valid;
  assign err_msg_fatal = st.msg_fatal;

  // ************************************
  // checks
  // ************************************
  chk_posted_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    dn_ta && dn_posted |=> dn_discard && !cpl_ca_valid)
    else $error("posted target-abort not dropped");

  chk_rta_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
    dn_ta |=> st.sstat[`BAH_SST_RTA] && st.ustat[`BAH_ERR_RTA])
    else $error("received target-abort flags not set");

  chk_ca_return: assert property (@(posedge ref_clk) disable iff (!rstn)
    dn_ta && !dn_posted |=> cpl_ca_valid && !dn_discard)
    else $error("no completer-abort completion");

  chk_log_first: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.ptr_valid && dn_ta && !st.umask[`BAH_ERR_RTA]
    |=> st.ptr_valid && !st.ptr_idx && st.hdr_log == $past(dn_hdr))
    else $error("first error header not logged");

  chk_msg_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
    err_msg_valid |-> $past(dn_ta && !st.umask[`BAH_ERR_RTA] || up_wr_perr && !st.umask[`BAH_ERR_UDE]))
    else $error("error message without unmasked error");

  chk_sserr_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    err_msg_valid && $past(st.ctrl[`BAH_CTL_SEE]) |-> st.pstat[`BAH_PST_SSERR])
    else $error("signaled system error not set");

  chk_det_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && st.usev[`BAH_ERR_UDE] |=> st.pstat[`BAH_PST_FDET])
    else $error("fatal detected flag not set");

  chk_perr_np: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && !up_posted && spr |=> perr_oe && !perr_out_n && up_discard && !up_fwd)
    else $error("non-posted parity error not discarded");

  chk_poison_np: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && !up_posted && !spr |=> up_fwd && up_poison && !perr_oe)
    else $error("non-posted parity error not poisoned");

  chk_posted_perr: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && up_posted |=> up_poison && (perr_oe == $past(spr)))
    else $error("posted parity error response wrong");

  chk_ptr_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.ptr_valid |=> $stable(st.hdr_log) && $stable(st.ptr_idx))
    else $error("logged header changed while pointer valid");

  chk_dpe_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr |=> st.sstat[`BAH_SST_DPE])
    else $error("detected parity error flag not set");

  chk_ude_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr |=> st.ustat[`BAH_ERR_UDE])
    else $error("uncorrectable write data flag not set");

  chk_nf_det: assert property (@(posedge ref_clk) disable iff (!rstn)
    dn_ta && !st.usev[`BAH_ERR_RTA] |=> st.pstat[`BAH_PST_NFDET])
    else $error("non-fatal detected flag not set");

  chk_poison_fwd: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && (up_posted || !spr) |=> up_fwd && up_poison && !up_discard)
    else $error("bad parity write not forwarded poisoned");

  chk_ur_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_cpl && up_cpl_ur && !up_cpl_ca && st.ctrl[`BAH_CTL_MAM] |=> pci_target_abort && !pci_normal)
    else $error("unsupported request not target-aborted");

  chk_ur_io_done: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_cpl && up_cpl_ur && !up_cpl_ca && up_cpl_io_wr && !st.ctrl[`BAH_CTL_MAM]
    |=> pci_normal && !pci_target_abort)
    else $error("unsupported i/o write not completed normally");

  chk_ptr_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.ptr_valid && !(wr_en && word_addr == `BAH_OFF_USTAT) |=> st.ptr_valid)
    else $error("pointer dropped without a status clear");

  chk_msg_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
    err_msg_valid |-> $past(st.ctrl[`BAH_CTL_SEE] || st.ctrl[`BAH_CTL_FEN] || st.ctrl[`BAH_CTL_NFEN]))
    else $error("error message sent while reporting disabled");

  chk_msg_fatal: assert property (@(posedge ref_clk) disable iff (!rstn)
    up_wr_perr && !dn_ta && !st.umask[`BAH_ERR_UDE] && st.usev[`BAH_ERR_UDE] && st.ctrl[`BAH_CTL_FEN]
    |=> err_msg_valid && err_msg_fatal)
    else $error("fatal data error message not sent");
endmodule

// [sim/bah_far.sv]
`timescale 1ns/1ps
module bah_far (
  // clock
  input  wire logic        ref_clk,
  // downstream abort events from the pci side
  output logic             dn_ta,
  output logic             dn_posted,
  output logic      [31:0] dn_hdr,
  // upstream writes claimed with bad parity
  output logic             up_wr_perr,
  output logic             up_posted,
  output logic      [31:0] up_hdr,
  // completions returned by the pcie side
  output logic             up_cpl,
  output logic             up_cpl_ur,
  output logic             up_cpl_ca,
  output logic             up_cpl_io_wr
);
  // *****
  // far side behaviour
  // *****
  // quiet lines at time zero
  initial begin
    {dn_ta, dn_posted, dn_hdr, up_wr_perr, up_posted, up_hdr} = '0;
    {up_cpl, up_cpl_ur, up_cpl_ca, up_cpl_io_wr} = '0;
  end
  // one-cycle event; qualifiers invert once released so a stale value cannot pass for a live one
  task automatic fire(input logic [1:0] k, input logic q, input logic [31:0] h, input logic [2:0] c);
    @(posedge ref_clk);
    dn_ta <= (k == 2'h0);
    up_wr_perr <= (k == 2'h1);
    up_cpl <= (k == 2'h2);
    {dn_posted, up_posted} <= {q, q};
    {dn_hdr, up_hdr} <= {h, h};
    {up_cpl_ur, up_cpl_ca, up_cpl_io_wr} <= c;
    @(posedge ref_clk);
    {dn_ta, up_wr_perr, up_cpl} <= 3'h0;
    {dn_posted, up_posted} <= {~q, ~q};
    {dn_hdr, up_hdr} <= {~h, ~h};
    {up_cpl_ur, up_cpl_ca, up_cpl_io_wr} <= ~c;
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "bah_params.svh"
module tb_top;
  // *****
  // signals
  // *****
  logic        ref_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        dn_ta;
  logic        dn_posted;
  logic [31:0] dn_hdr;
  logic        dn_discard;
  logic        cpl_ca_valid;
  logic        up_wr_perr;
  logic        up_posted;
  logic [31:0] up_hdr;
  logic        up_fwd;
  logic        up_poison;
  logic        up_discard;
  logic        perr_out_n;
  logic        perr_oe;
  logic        up_cpl;
  logic        up_cpl_ur;
  logic        up_cpl_ca;
  logic        up_cpl_io_wr;
  logic        pci_target_abort;
  logic        pci_normal;
  logic [31:0] pci_rdata;
  logic        err_msg_valid;
  logic        err_msg_fatal;
  logic [10:0] pins;
  logic [31:0] rd_q;
  logic        rd_err;
  logic [2:0]  cst;
  int          mismatches;
  int          tests_run;

  // *****
  // design and far side
  // *****
  bah_top i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dn_ta(dn_ta), .dn_posted(dn_posted), .dn_hdr(dn_hdr), .dn_discard(dn_discard),
    .cpl_ca_valid(cpl_ca_valid), .up_wr_perr(up_wr_perr), .up_posted(up_posted),
    .up_hdr(up_hdr), .up_fwd(up_fwd), .up_poison(up_poison), .up_discard(up_discard),
    .perr_out_n(perr_out_n), .perr_oe(perr_oe), .up_cpl(up_cpl), .up_cpl_ur(up_cpl_ur),
    .up_cpl_ca(up_cpl_ca), .up_cpl_io_wr(up_cpl_io_wr), .pci_target_abort(pci_target_abort),
    .pci_normal(pci_normal), .pci_rdata(pci_rdata), .err_msg_valid(err_msg_valid),
    .err_msg_fatal(err_msg_fatal));
  bah_far i_far (
    .ref_clk(ref_clk), .dn_ta(dn_ta), .dn_posted(dn_posted), .dn_hdr(dn_hdr),
    .up_wr_perr(up_wr_perr), .up_posted(up_posted), .up_hdr(up_hdr), .up_cpl(up_cpl),
    .up_cpl_ur(up_cpl_ur), .up_cpl_ca(up_cpl_ca), .up_cpl_io_wr(up_cpl_io_wr));

  // fatal bit only counts while a message is offered
  assign pins = {dn_discard, cpl_ca_valid, up_fwd, up_poison, up_discard, perr_oe, perr_out_n,
                 err_msg_valid, err_msg_valid & err_msg_fatal, pci_target_abort, pci_normal};

  // 20 mhz clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // *****
  // tasks
  // *****
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: pins %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd_q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // one event, then its answer one edge later, then quiet again
  task automatic ev(input logic [1:0] k, input logic q, input logic [31:0] h, input logic [10:0] e);
    i_far.fire(k, q, h, 3'h0);
    #1;
    chk_pin(pins, e);
    @(posedge ref_clk);
    #1;
    chk_pin(pins, 11'h010);
  endtask
  task automatic tdone(input string n);
    $display("test %s done, mismatches so far %0d", n, mismatches);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // *****
  // sequence
  // *****
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    // reset values; the word past the map is refused
    for (int a = 0; a <= 32; a += 4) begin
      if (a != 28) begin
        rd(a[11:0], 32'h0000_0000);
        chk_word({31'h0, rd_err}, {31'h0, a == 32});
      end
    end
    tdone("reset");
    // posted abort: drop the rest, flag, log, non-fatal message
    wr(`BAH_OFF_CTRL, 32'h0000_0001);
    ev(2'h0, 1'b1, 32'hA5A5_0001, 11'h418);
    rd(`BAH_OFF_SSTAT, 32'h0000_0001);
    rd(`BAH_OFF_USTAT, 32'h0000_0001);
    rd(`BAH_OFF_PSTAT, 32'h0000_0009);
    rd(`BAH_OFF_PTR, 32'h0000_0010);
    rd(`BAH_OFF_HLOG, 32'hA5A5_0001);
    tdone("posted abort");
    // non-posted abort at fatal severity; the log stays frozen
    wr(`BAH_OFF_USEV, 32'h0000_0001);
    ev(2'h0, 1'b0, 32'h5A5A_0002, 11'h21C);
    rd(`BAH_OFF_PSTAT, 32'h0000_000D);
    rd(`BAH_OFF_PTR, 32'h0000_0010);
    rd(`BAH_OFF_HLOG, 32'hA5A5_0001);
    wr(`BAH_OFF_USTAT, 32'h0000_0001);
    rd(`BAH_OFF_PTR, 32'h0000_0000);
    tdone("non-posted abort");
    // masked data error with parity response off: poisoned, silent
    wr(`BAH_OFF_USEV, 32'h0000_0000);
    wr(`BAH_OFF_UMASK, 32'h0000_0002);
    ev(2'h1, 1'b1, 32'hC0C0_0003, 11'h190);
    rd(`BAH_OFF_SSTAT, 32'h0000_0003);
    rd(`BAH_OFF_USTAT, 32'h0000_0002);
    rd(`BAH_OFF_PTR, 32'h0000_0000);
    // parity response on, then off again for non-posted
    wr(`BAH_OFF_CTRL, 32'h0000_0009);
    ev(2'h1, 1'b1, 32'hC0C0_0004, 11'h1A0);
    rd(`BAH_OFF_SSTAT, 32'h0000_0007);
    ev(2'h1, 1'b0, 32'hC0C0_0005, 11'h060);
    wr(`BAH_OFF_CTRL, 32'h0000_0001);
    ev(2'h1, 1'b0, 32'hC0C0_0006, 11'h190);
    tdone("data errors");
    // fatal enable alone sends a message but no system-error flag
    wr(`BAH_OFF_UMASK, 32'h0000_0000);
    wr(`BAH_OFF_USEV, 32'h0000_0002);
    wr(`BAH_OFF_CTRL, 32'h0000_0002);
    wr(`BAH_OFF_PSTAT, 32'h0000_000F);
    ev(2'h1, 1'b1, 32'hD0D0_0007, 11'h19C);
    rd(`BAH_OFF_PSTAT, 32'h0000_0004);
    rd(`BAH_OFF_PTR, 32'h0000_0011);
    rd(`BAH_OFF_HLOG, 32'hD0D0_0007);
    tdone("fatal enable");
    // completions in both modes: ur read, ur i/o write, completer abort, plain
    for (int m = 0; m < 2; m++) begin
      wr(`BAH_OFF_CTRL, (m == 1) ? 32'h0000_0010 : 32'h0000_0000);
      for (int j = 0; j < 4; j++) begin
        cst = (j == 0) ? 3'h4 : (j == 1) ? 3'h5 : (j == 2) ? 3'h2 : 3'h0;
        i_far.fire(2'h2, 1'b0, 32'h0000_0000, cst);
        #1;
        chk_pin(pins, (j == 3) ? 11'h010 : (m == 1 || j == 2) ? 11'h012 : 11'h011);
        if (j < 3)
          chk_word(pci_rdata, (m == 0 && j == 0) ? 32'hFFFF_FFFF : 32'h0000_0000);
      end
    end
    tdone("completions");
    summarize();
  end

  // watchdog: the sequence needs under two hundred cycles
  initial begin
    #100_000;
    mismatches++;
    summarize();
  end
endmodule
